/* hw/adc_result_monitor_pkg.sv */
// constants and types for the conversion result monitor and statistics block
`default_nettype none
package adc_result_monitor_pkg;
   localparam int ADDR_W = 14;
   localparam logic [ADDR_W-1:0] UPPER_LIMIT_VALUE_ADDR = 14'h20b0;
   localparam logic [ADDR_W-1:0] UPPER_LIMIT_HYST_ADDR  = 14'h20b4;
   localparam logic [ADDR_W-1:0] RESULT_DELTA_ADDR      = 14'h20b8;
   localparam logic [ADDR_W-1:0] STATS_VARIANCE_ADDR    = 14'h21c0;
   localparam logic [ADDR_W-1:0] STATS_CONTROL_ADDR     = 14'h21c4;
   localparam logic [ADDR_W-1:0] STATS_MEAN_ADDR        = 14'h21c8;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR        = 14'h21d0;
   localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR         = 14'h21d4;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR        = 14'h21d8;

   localparam int OVER_LIMIT_BIT  = 5;
   localparam int DELTA_ERROR_BIT = 6;
   localparam int IRQ_W           = 7;
   localparam logic [IRQ_W-1:0] IRQ_USED_MASK = 7'h60;

   localparam int STATS_EN_BIT = 0;
   localparam int SEL_LO       = 4;
   localparam int SEL_HI       = 6;
   localparam int SIGMA_LO     = 7;
   localparam int SIGMA_HI     = 11;
   localparam int CTRL_W       = 12;
   localparam logic [CTRL_W-1:0] CTRL_WR_MASK = 12'hfff;

   localparam int ACC_W   = 23;
   localparam int SQ_W    = 39;
   localparam int CNT_W   = 8;
   localparam int SHIFT_W = 3;
   localparam int VAR_W   = 31;
   localparam logic [31:0] REG_RESET = 32'h0;

   typedef struct packed {
      logic                 wr;
      logic                 rd;
      logic [ADDR_W-1:0]    addr;
      logic [31:0]          wdata;
   } bus_req_s;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_COLLECT = 2'b01,
      ST_FINISH  = 2'b11
   } stats_state_e;
endpackage
`default_nettype wire

/* hw/adc_result_monitor_stats.sv */
// result limit, delta checks and mean/variance statistics for conversion results
// How it works
// - a result above the upper limit value sets the over-limit flag (bit 5).
// - the over-limit flag stays set until a result falls below the limit minus the hysteresis value.
// - each result after the first since reset is compared with the previous one and a difference above the delta limit sets flag 6.
// - bit 0 of stats control enables the statistics unit; 0 stops it and clears its accumulators, while mean and variance keep their last values.
// - bits 6:4 choose 128, 64, 32, 16 or 8 samples per statistic for codes 0 to 4.
// - after each block the 16-bit mean is shown in the read-only mean register.
// - after each block the 31-bit variance is shown with bit 31 reading zero.
// - the upper limit value register holds the 16-bit limit used by the over-limit check.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module adc_result_monitor_stats
   import adc_result_monitor_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              result_valid_i,
   input  wire logic [15:0]       conversion_result_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [31:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic [31:0]            rdata_o,
   output logic                   irq_o
);

   bus_req_s           req;
   logic [15:0]        upper_limit_value_q;
   logic [15:0]        upper_limit_hysteresis_q;
   logic [15:0]        delta_limit_field_q;
   logic [CTRL_W-1:0]  stats_control_q;
   logic [IRQ_W-1:0]   irq_status_q;
   logic [IRQ_W-1:0]   irq_enable_q;
   logic [15:0]        prev_result_q;
   logic               prev_valid_q;
   logic               over_state_q;
   logic [15:0]        stats_mean_out_q;
   logic [VAR_W-1:0]   stats_variance_out_q;
   logic [ACC_W-1:0]   sum_q;
   logic [SQ_W-1:0]    sq_sum_q;
   logic [CNT_W-1:0]   count_q;
   stats_state_e       state_q;
   logic               over_set;
   logic               over_rel;
   logic               delta_set;
   logic [IRQ_W-1:0]   irq_set;
   logic [IRQ_W-1:0]   irq_clr;
   logic [SHIFT_W-1:0] shift;
   logic [CNT_W-1:0]   block_len;
   logic               stats_en;
   logic [IRQ_W-1:0]   irq_status_d;
   logic [31:0]        rdata_d;

   assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
   assign stats_en = stats_control_q[STATS_EN_BIT];

   // absolute difference of two unsigned results
   function automatic logic [16:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
      abs_diff = (a > b) ? ({1'b0, a} - {1'b0, b}) : ({1'b0, b} - {1'b0, a});
   endfunction

   // log2 of the block length; codes above 4 fall back to 8 samples
   function automatic logic [SHIFT_W-1:0] sel_shift(input logic [SEL_HI-SEL_LO:0] sel);
      case (sel)
         3'h0:    sel_shift = 3'h7;
         3'h1:    sel_shift = 3'h6;
         3'h2:    sel_shift = 3'h5;
         3'h3:    sel_shift = 3'h4;
         default: sel_shift = 3'h3;
      endcase
   endfunction

   // codes 5 to 7 are undefined; treated as the shortest block
   assign shift     = sel_shift(stats_control_q[SEL_HI:SEL_LO]);
   assign block_len = CNT_W'(8'h1 << shift);

   // release level computed wide so a hysteresis above the limit cannot wrap
   assign over_set = result_valid_i && (conversion_result_i > upper_limit_value_q);
   assign over_rel = result_valid_i &&
                     ({1'b0, conversion_result_i} + {1'b0, upper_limit_hysteresis_q}
                      < {1'b0, upper_limit_value_q});
   assign delta_set = result_valid_i && prev_valid_q &&
                      (abs_diff(conversion_result_i, prev_result_q) > {1'b0, delta_limit_field_q});

   always_comb
   begin
      irq_set = '0;
      irq_set[OVER_LIMIT_BIT]  = over_set || (over_state_q && !over_rel);
      irq_set[DELTA_ERROR_BIT] = delta_set;
      irq_clr = (req.wr && req.addr == IRQ_CLEAR_ADDR) ? req.wdata[IRQ_W-1:0] : '0;
   end

   // next status, shared so the interrupt sees a set in the same edge
   assign irq_status_d = (irq_status_q & ~irq_clr) | irq_set;

   // upper limit value
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         upper_limit_value_q <= REG_RESET[15:0];
      else if (req.wr && req.addr == UPPER_LIMIT_VALUE_ADDR)
         upper_limit_value_q <= req.wdata[15:0];
   end

   // upper limit hysteresis
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         upper_limit_hysteresis_q <= REG_RESET[15:0];
      else if (req.wr && req.addr == UPPER_LIMIT_HYST_ADDR)
         upper_limit_hysteresis_q <= req.wdata[15:0];
   end

   // delta limit
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         delta_limit_field_q <= REG_RESET[15:0];
      else if (req.wr && req.addr == RESULT_DELTA_ADDR)
         delta_limit_field_q <= req.wdata[15:0];
   end

   // stats control, reserved bits 3:1 kept read/write
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         stats_control_q <= REG_RESET[CTRL_W-1:0];
      else if (req.wr && req.addr == STATS_CONTROL_ADDR)
         stats_control_q <= req.wdata[CTRL_W-1:0] & CTRL_WR_MASK;
   end

   // interrupt enable, only the two used flags
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         irq_enable_q <= REG_RESET[IRQ_W-1:0];
      else if (req.wr && req.addr == IRQ_ENABLE_ADDR)
         irq_enable_q <= req.wdata[IRQ_W-1:0] & IRQ_USED_MASK;
   end

   // hysteresis state: held from a crossing until the release level is seen
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         over_state_q <= 1'b0;
      else if (over_set)
         over_state_q <= 1'b1;
      else if (over_rel)
         over_state_q <= 1'b0;
   end

   // previous result for the delta check; first result after reset has no partner
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         prev_result_q <= REG_RESET[15:0];
         prev_valid_q  <= 1'b0;
      end
      else if (result_valid_i)
      begin
         prev_result_q <= conversion_result_i;
         prev_valid_q  <= 1'b1;
      end
   end

   // sticky status; a set in the clear cycle wins.  a still-high over-limit re-sets
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         irq_status_q <= REG_RESET[IRQ_W-1:0];
      else
         irq_status_q <= irq_status_d;
   end

   // level interrupt, registered so the pin comes straight from a flop
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(irq_status_d & irq_enable_q);
   end

   // statistics: sum and sum of squares, var = E[x^2] - mean^2
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_q  <= ST_IDLE;
         sum_q    <= '0;
         sq_sum_q <= '0;
         count_q  <= '0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               // disabled: accumulators held empty so a re-enable starts clean
               sum_q    <= '0;
               sq_sum_q <= '0;
               count_q  <= '0;
               if (stats_en)
                  state_q <= ST_COLLECT;
            end
            ST_COLLECT:
            begin
               if (!stats_en)
                  state_q <= ST_IDLE;
               else if (result_valid_i)
               begin
                  sum_q    <= sum_q + ACC_W'(conversion_result_i);
                  // full 32-bit squares; 128 of them still fit in 39 bits
                  sq_sum_q <= sq_sum_q + (SQ_W'(conversion_result_i) * SQ_W'(conversion_result_i));
                  count_q  <= count_q + 8'h1;
                  if (count_q + 8'h1 == block_len)
                     state_q <= ST_FINISH;
               end
            end
            ST_FINISH:
            begin
               // one cycle to publish; a result arriving here is not counted
               state_q <= stats_en ? ST_COLLECT : ST_IDLE;
               sum_q    <= '0;
               sq_sum_q <= '0;
               count_q  <= '0;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   logic [15:0]     mean_w;
   logic [SQ_W-1:0] msq_w;
   logic [SQ_W-1:0] mean_sq_w;
   assign mean_w    = 16'(sum_q >> shift);
   assign msq_w     = sq_sum_q >> shift;
   // widened before multiplying, a 16-bit product would lose the top half
   assign mean_sq_w = SQ_W'(mean_w) * SQ_W'(mean_w);

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         stats_mean_out_q     <= REG_RESET[15:0];
         stats_variance_out_q <= REG_RESET[VAR_W-1:0];
      end
      else if (state_q == ST_FINISH)
      begin
         stats_mean_out_q     <= mean_w;
         stats_variance_out_q <= (msq_w > mean_sq_w) ? VAR_W'(msq_w - mean_sq_w) : '0;
      end
   end

   // read decode; unmapped and write-only addresses read as zero
   always_comb
   begin
      rdata_d = REG_RESET;
      if (!req.rd)
         rdata_d = REG_RESET;
      else if (req.addr == UPPER_LIMIT_VALUE_ADDR)
         rdata_d = {16'h0, upper_limit_value_q};
      else if (req.addr == UPPER_LIMIT_HYST_ADDR)
         rdata_d = {16'h0, upper_limit_hysteresis_q};
      else if (req.addr == RESULT_DELTA_ADDR)
         rdata_d = {16'h0, delta_limit_field_q};
      else if (req.addr == STATS_VARIANCE_ADDR)
         rdata_d = {1'b0, stats_variance_out_q};
      else if (req.addr == STATS_CONTROL_ADDR)
         rdata_d = {20'h0, stats_control_q};
      else if (req.addr == STATS_MEAN_ADDR)
         rdata_d = {16'h0, stats_mean_out_q};
      else if (req.addr == IRQ_STATUS_ADDR)
         rdata_d = {25'h0, irq_status_q};
      else if (req.addr == IRQ_ENABLE_ADDR)
         rdata_d = {25'h0, irq_enable_q};
      else
         rdata_d = REG_RESET;
   end

   // read data, one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rdata_o <= REG_RESET;
      else
         rdata_o <= rdata_d;
   end

endmodule
`default_nettype wire

/* dv/adc_result_source.sv */
// behavioural conversion datapath feeding results
`timescale 1ns/100ps
`default_nettype none
module adc_result_source (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        send_i,
   input  wire logic [15:0] value_i,
   output logic             result_valid_o,
   output logic [15:0]      result_o
);
   // bus scrambled between results so a stale value is never trusted
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         result_valid_o <= 1'b0;
         result_o       <= 16'h0;
      end
      else
      begin
         result_valid_o <= send_i;
         result_o       <= send_i ? value_i : ~result_o;
      end
   end
endmodule
`default_nettype wire

/* dv/adc_result_monitor_stats_assertions.sv */
// checker on the monitor's ports
`timescale 1ns/100ps
`default_nettype none
module adc_result_monitor_stats_assertions
   import adc_result_monitor_pkg::*;
(
   input wire logic              clk_i,
   input wire logic              sys_rst_i,
   input wire logic              result_valid_i,
   input wire logic [15:0]       conversion_result_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [31:0]       wdata_i,
   input wire logic              wr_i,
   input wire logic              rd_i,
   input wire logic [31:0]       rdata_o,
   input wire logic              irq_o
);
   logic [15:0] lim_q, hyst_q, dlt_q, prev_q;
   logic [11:0] ctrl_q;
   logic [1:0]  en_q;
   logic        over_q, seen_q;
   wire  [15:0] res  = conversion_result_i;
   wire  [15:0] diff = (res > prev_q) ? res - prev_q : prev_q - res;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         {lim_q, hyst_q, dlt_q, ctrl_q, en_q} <= '0;
      else if (wr_i)
         case (addr_i)
            UPPER_LIMIT_VALUE_ADDR: lim_q <= wdata_i[15:0];
            UPPER_LIMIT_HYST_ADDR: hyst_q <= wdata_i[15:0];
            RESULT_DELTA_ADDR: dlt_q <= wdata_i[15:0];
            STATS_CONTROL_ADDR: ctrl_q <= wdata_i[11:0];
            IRQ_ENABLE_ADDR: en_q <= wdata_i[6:5];
            default: ;
         endcase
   end
   // release is strict, so equality with limit minus hysteresis still holds
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         {over_q, seen_q, prev_q} <= '0;
      else if (result_valid_i)
      begin
         seen_q <= 1'b1;
         prev_q <= res;
         over_q <= (res > lim_q) || (over_q && ({1'b0, res} + {1'b0, hyst_q} >= {1'b0, lim_q}));
      end
   end
   a_over_irq: assert property (result_valid_i && res > lim_q && en_q[0] |-> ##2 irq_o)
      else $error("over-limit result gave no interrupt");
   a_over_hold: assert property ((over_q && en_q[0]) [*3] |-> irq_o)
      else $error("over-limit flag dropped while held");
   a_delta_irq: assert property (result_valid_i && seen_q && diff > dlt_q && en_q[1] |-> ##2 irq_o)
      else $error("delta error gave no interrupt");
   a_irq_masked: assert property ((en_q == 2'b00) [*2] |-> !irq_o)
      else $error("interrupt high while masked");
   a_ctrl_back: assert property (rd_i && addr_i == STATS_CONTROL_ADDR |=> rdata_o == {20'h0, $past(ctrl_q)})
      else $error("control readback wrong");
   a_limit_back: assert property (rd_i && addr_i == UPPER_LIMIT_VALUE_ADDR |=> rdata_o == {16'h0, $past(lim_q)})
      else $error("limit readback wrong");
   a_mean_width: assert property (rd_i && addr_i == STATS_MEAN_ADDR |=> rdata_o[31:16] == 16'h0)
      else $error("mean upper half not zero");
   a_var_reserved: assert property (rd_i && addr_i == STATS_VARIANCE_ADDR |=> !rdata_o[31])
      else $error("variance bit 31 set");
   c_over: cover property (result_valid_i && res > lim_q);
   c_delta: cover property (result_valid_i && seen_q && diff > dlt_q);
   c_mean_rd: cover property (rd_i && addr_i == STATS_MEAN_ADDR);
endmodule
bind adc_result_monitor_stats adc_result_monitor_stats_assertions checker_inst (
   .clk_i, .sys_rst_i, .result_valid_i, .conversion_result_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o
);
`default_nettype wire

/* dv/adc_result_monitor_stats_tb.sv */
// self-checking bench for the result monitor
`timescale 1ns/100ps
`default_nettype none
module adc_result_monitor_stats_tb
   import adc_result_monitor_pkg::*;
;
   logic              clk_i, sys_rst_i, wr_i, rd_i, send, valid, irq_o;
   logic [ADDR_W-1:0] addr_i;
   logic [31:0]       wdata_i, rdata_o, d;
   logic [15:0]       value, res, v;
   int                mismatches, n_checks, seed, n;
   longint            s, sq;
   logic [ADDR_W-1:0] regs[4] = '{UPPER_LIMIT_VALUE_ADDR, UPPER_LIMIT_HYST_ADDR, RESULT_DELTA_ADDR, STATS_CONTROL_ADDR};
   logic [ADDR_W-1:0] rst_regs[7] = '{RESULT_DELTA_ADDR, STATS_VARIANCE_ADDR, STATS_CONTROL_ADDR,
                                      STATS_MEAN_ADDR, IRQ_STATUS_ADDR, IRQ_ENABLE_ADDR, 14'h2000};
   adc_result_source adc_result_source_inst (.clk_i, .sys_rst_i, .send_i(send), .value_i(value),
                                             .result_valid_o(valid), .result_o(res));
   adc_result_monitor_stats adc_result_monitor_stats_inst (.clk_i, .sys_rst_i, .result_valid_i(valid),
      .conversion_result_i(res), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o);
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dat);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= dat;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rdc(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(what, rdata_o, exp);
   endtask
   // source adds one cycle, flag and interrupt one more, both on the same edge
   task automatic send_res(input logic [15:0] x);
      @(posedge clk_i);
      send <= 1'b1;
      value <= x;
      @(posedge clk_i);
      send <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   // mean of squares minus squared mean, floored and clipped at zero
   function automatic logic [31:0] var_exp(input longint sm, input longint sqs, input int cnt);
      longint m;
      m = sm / cnt;
      return (sqs / cnt > m * m) ? 32'(sqs / cnt - m * m) : 32'h0;
   endfunction
   task automatic end_sim();
      if (mismatches == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (30000) @(posedge clk_i);
      mismatches++;
      end_sim();
   end
   initial
   begin
      {sys_rst_i, wr_i, rd_i, send, addr_i, wdata_i, value} = {1'b1, 65'h0};
      seed = 32'h16bc1387;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      foreach (rst_regs[i]) rdc("reset value", rst_regs[i], 32'h0);
      wr(STATS_MEAN_ADDR, 32'hffffffff);
      rdc("mean read-only", STATS_MEAN_ADDR, 32'h0);
      foreach (regs[i])
      begin
         d = $random(seed);
         wr(regs[i], d & 32'hfffffffe);
         rdc("readback", regs[i], d & (i == 3 ? 32'hffe : 32'hfffe));
      end
      wr(UPPER_LIMIT_VALUE_ADDR, 32'd100);
      wr(UPPER_LIMIT_HYST_ADDR, 32'd10);
      wr(RESULT_DELTA_ADDR, 32'hffff);
      wr(IRQ_ENABLE_ADDR, 32'h60);
      send_res(16'd100);
      rdc("equal to limit", IRQ_STATUS_ADDR, 32'h0);
      send_res(16'd101);
      chk("over irq", irq_o, 1'b1);
      send_res(16'd90);
      wr(IRQ_CLEAR_ADDR, 32'h20);
      rdc("held flag", IRQ_STATUS_ADDR, 32'h20);
      send_res(16'd89);
      wr(IRQ_CLEAR_ADDR, 32'h20);
      rdc("released flag", IRQ_STATUS_ADDR, 32'h0);
      chk("irq off", irq_o, 1'b0);
      wr(UPPER_LIMIT_VALUE_ADDR, 32'hffff);
      wr(RESULT_DELTA_ADDR, 32'd5);
      wr(IRQ_ENABLE_ADDR, 32'h20);
      send_res(16'd55);
      wr(IRQ_CLEAR_ADDR, 32'h40);
      send_res(16'd60);
      rdc("delta at limit", IRQ_STATUS_ADDR, 32'h0);
      send_res(16'd54);
      rdc("delta falling", IRQ_STATUS_ADDR, 32'h40);
      chk("delta masked", irq_o, 1'b0);
      wr(IRQ_ENABLE_ADDR, 32'h40);
      send_res(16'd70);
      chk("delta irq", irq_o, 1'b1);
      for (int sel = 0; sel < 5; sel++)
      begin
         n = 128 >> sel;
         s = 0;
         sq = 0;
         wr(STATS_CONTROL_ADDR, 32'h0);
         wr(STATS_CONTROL_ADDR, 32'(sel << 4) | 32'h1);
         for (int i = 0; i < n; i++)
         begin
            @(posedge clk_i);
            v = 16'($random(seed));
            send <= 1'b1;
            value <= v;
            s += v;
            sq += longint'(v) * v;
         end
         @(posedge clk_i);
         send <= 1'b0;
         repeat (4) @(posedge clk_i);
         rdc("mean", STATS_MEAN_ADDR, 32'(s / n));
         rdc("variance", STATS_VARIANCE_ADDR, var_exp(s, sq, n));
      end
      wr(STATS_CONTROL_ADDR, 32'h0);
      repeat (8) send_res(16'h0);
      rdc("disabled mean", STATS_MEAN_ADDR, 32'(s / n));
      end_sim();
   end
endmodule
`default_nettype wire
